// file: hw/efm_fault_monitor.sv
// fault monitor: sensor ranges, position signals, actuator drivers, codes
`default_nettype none
module efm_fault_monitor #(
   parameter int NS = 4,
   parameter int NV = 6,
   parameter int NP = 2,
   parameter int CTRL_TMO_CYC = efm_pkg::CTRL_TMO_CYC
) (
   // clock and power-up reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // calibration
   input wire efm_pkg::efm_cal_type cal_in,
   input wire logic cal_load_in,
   // sensor samples
   input wire logic sens_valid_in,
   input wire logic [$clog2(NS)-1:0] sens_idx_in,
   input wire logic [efm_pkg::SENS_W-1:0] sens_val_in,
   // position sensor pins
   input wire logic crank_mark_in,
   input wire logic cam_mark_in,
   input wire logic crank_gnd_open_in,
   input wire logic cam_gnd_open_in,
   input wire logic crank_pol_in,
   input wire logic cam_pol_in,
   input wire logic diag_routine_in,
   // injector solenoid valves
   input wire logic [NV-1:0] inj_cmd_in,
   input wire logic [NV-1:0] inj_short_in,
   input wire logic [NV-1:0] inj_contact_in,
   input wire logic [NV-1:0] inj_cur_ok_in,
   // proportional valves and starter
   input wire logic [NP-1:0] prop_cmd_in,
   input wire logic [NP-1:0] prop_short_in,
   input wire logic starter_cmd_in,
   input wire logic starter_short_in,
   input wire logic starter_open_in,
   // tester access
   input wire logic [$clog2(8+NS+3*NV+NP)-1:0] rd_idx_in,
   input wire logic clr_req_in,
   input wire logic [$clog2(8+NS+3*NV+NP)-1:0] clr_idx_in,
   // results
   output logic [NS-1:0][efm_pkg::SENS_W-1:0] sens_value_out,
   output efm_pkg::efm_pos_type pos_src_out,
   output logic [NV-1:0] inj_drive_out,
   output logic [NV-1:0][efm_pkg::TMR_W-1:0] inj_adv_out,
   output logic [NP-1:0] prop_drive_out,
   output logic starter_drive_out,
   output efm_pkg::efm_code_type rd_code_out,
   output logic rd_stored_out,
   output logic rd_present_out,
   output logic fault_any_out
);
   import efm_pkg::*;

   // ==========================================================
   // slot map and pin layout
   localparam int IB = SLOT_SENS + NS;
   localparam int CB = IB + NV;
   localparam int LB = CB + NV;
   localparam int PB = LB + NV;
   localparam int NF = PB + NP;
   localparam int FW = $clog2(NF);
   localparam int P_CT = P_ISH + NV;
   localparam int P_COK = P_CT + NV;
   localparam int P_PSH = P_COK + NV;
   localparam int P_SSH = P_PSH + NP;
   localparam int P_SOP = P_SSH + 1;
   localparam int AW = P_SOP + 1;
   localparam logic [TMR_W-1:0] CTRL_LAST = TMR_W'(CTRL_TMO_CYC - 1);

   typedef struct packed {
      logic [AW-1:0] s1;
      logic [AW-1:0] s2;
      logic [AW-1:0] s3;
      logic [AW-1:0] pin;
      efm_cal_type cal;
      logic crk_arm;
      logic cam_arm;
      logic [15:0] crk_tmr;
      logic [15:0] cam_tmr;
      efm_pos_type pos;
      logic [NS-1:0] oor;
      logic [NS-1:0] shi;
      logic [NS-1:0][15:0] deb;
      logic [NS-1:0][SENS_W-1:0] sval;
      logic [NS-1:0][SENS_W-1:0] sout;
      logic [NV-1:0] inj_drv;
      logic [NV-1:0] shseen;
      logic [NV-1:0] cdone;
      logic [NV-1:0] iok;
      logic [NV-1:0] ctf;
      logic [NV-1:0] clf;
      logic [NV-1:0][TMR_W-1:0] tmr;
      logic [NV-1:0][TMR_W-1:0] adv;
      logic [NV-1:0][2:0] icnt;
      logic [NP-1:0] p_drv;
      logic [NP-1:0] p_seen;
      logic [NP-1:0][2:0] pcnt;
      logic str_drv;
      logic str_seen;
      logic [2:0] scnt;
      logic [NF-1:0] st;
      logic [NF-1:0] pres;
      efm_code_type rd_code;
      logic rd_st;
      logic rd_pr;
      logic any;
   } efm_state_type;

   efm_state_type s;
   efm_state_type n;

   // successive shorted activations, saturating at the limit
   function automatic logic [2:0] succ(input logic [2:0] c,
                                       input logic seen,
                                       input logic [2:0] lim);
      if (!seen)
         return 3'h0;
      return (c >= lim) ? c : 3'(c + 3'h1);
   endfunction

   function automatic efm_code_type code_of(input int i,
                                            input logic [NS-1:0] hi);
      logic [6:0] p;
      logic [6:0] t;
      logic [3:0] w;
      p = PATH_STARTER;
      t = TYP_GND;
      w = PRIO_HIGH;
      case (i)
         F_CRK_TMO: begin p = PATH_CRANK; t = TYP_TMO; w = PRIO_MID; end
         F_CRK_POL: begin p = PATH_CRANK; t = TYP_POL; w = PRIO_MID; end
         F_CRK_GO: begin p = PATH_CRANK; t = TYP_GND; w = PRIO_MID; end
         F_CAM_TMO: begin p = PATH_CAM; t = TYP_TMO; w = PRIO_MID; end
         F_CAM_POL: begin p = PATH_CAM; t = TYP_POL; w = PRIO_MID; end
         F_CAM_GO: begin p = PATH_CAM; t = TYP_GND; w = PRIO_MID; end
         F_STR_SH: w = PRIO_HIGH;
         F_STR_OPEN: begin t = TYP_OPEN; w = PRIO_LOW; end
         default: begin
            if (i < IB) begin
               p = 7'(PATH_SENS0 + 7'(i - SLOT_SENS));
               t = hi[i - SLOT_SENS] ? TYP_OVER : TYP_GND;
               w = PRIO_LOW;
            end else if (i < PB) begin
               p = 7'(PATH_INJ0 + 7'((i - IB) % NV));
               t = (i < CB) ? TYP_GND : (i < LB) ? TYP_CONTACT : TYP_CTRL;
            end else begin
               p = 7'(PATH_PROP0 + 7'(i - PB));
            end
         end
      endcase
      return '{prio: w, path: to_bcd(p), ftype: to_bcd(t)};
   endfunction

   // ==========================================================
   // next state
   always_comb begin
      logic [AW-1:0] rise;
      logic [NF-1:0] pres;
      logic [NF-1:0] set;
      logic fin;
      logic crk_bad;
      logic cam_bad;
      n = s;
      pres = '0;
      set = '0;
      fin = 1'b0;
      rise = '0;
      crk_bad = 1'b0;
      cam_bad = 1'b0;
      // three-stage pin filter: a change counts when stages two and three agree
      n.s1 = {starter_open_in, starter_short_in, prop_short_in,
              inj_cur_ok_in, inj_contact_in, inj_short_in, diag_routine_in,
              cam_pol_in, crank_pol_in, cam_gnd_open_in, crank_gnd_open_in,
              cam_mark_in, crank_mark_in};
      n.s2 = s.s1;
      n.s3 = s.s2;
      n.pin = (s.s2 & s.s3) | (s.pin & (s.s2 | s.s3));
      rise = n.pin & ~s.pin;
      if (cal_load_in)
         n.cal = cal_in;

      // position sensors: timers arm on the first mark so a stopped engine
      // does not log time-outs
      if (rise[P_CRK]) begin
         n.crk_arm = 1'b1;
         n.crk_tmr = '0;
      end else if (s.crk_arm && s.crk_tmr != s.cal.crank_tmo)
         n.crk_tmr = 16'(s.crk_tmr + 16'h1);
      if (rise[P_CAM]) begin
         n.cam_arm = 1'b1;
         n.cam_tmr = '0;
      end else if (s.cam_arm && s.cam_tmr != s.cal.cam_tmo)
         n.cam_tmr = 16'(s.cam_tmr + 16'h1);
      pres[F_CRK_TMO] = s.crk_arm && s.crk_tmr == s.cal.crank_tmo;
      pres[F_CAM_TMO] = s.cam_arm && s.cam_tmr == s.cal.cam_tmo;
      pres[F_CRK_GO] = s.pin[P_CRKGO];
      pres[F_CAM_GO] = s.pin[P_CAMGO];
      pres[F_CRK_POL] = s.pin[P_CRKPOL] && s.pin[P_DIAG];
      pres[F_CAM_POL] = s.pin[P_CAMPOL];
      crk_bad = pres[F_CRK_TMO] | pres[F_CRK_GO];
      cam_bad = pres[F_CAM_TMO] | pres[F_CAM_GO];
      if (crk_bad)
         n.pos = POS_CAM;
      else if (cam_bad)
         n.pos = POS_CRANK;
      else
         n.pos = POS_NORMAL;

      // sensor ranges
      for (int i = 0; i < NS; i++) begin
         if (sens_valid_in && int'(sens_idx_in) == i) begin
            if (sens_val_in < s.cal.sens_min ||
                sens_val_in > s.cal.sens_max) begin
               n.oor[i] = 1'b1;
               n.shi[i] = sens_val_in > s.cal.sens_max;
            end else begin
               n.oor[i] = 1'b0;
               n.deb[i] = '0;
               n.sval[i] = sens_val_in;
            end
         end
         if (s.oor[i] && s.deb[i] != s.cal.sens_deb)
            n.deb[i] = 16'(s.deb[i] + 16'h1);
         pres[SLOT_SENS + i] = s.oor[i] && s.deb[i] == s.cal.sens_deb;
         n.sout[i] = s.st[SLOT_SENS + i] ? SENS_REPL : n.sval[i];
      end

      // injector solenoid valves
      for (int v = 0; v < NV; v++) begin
         n.inj_drv[v] = inj_cmd_in[v] && !s.st[IB + v];
         if (n.inj_drv[v] && !s.inj_drv[v]) begin
            n.tmr[v] = '0;
            n.shseen[v] = 1'b0;
            n.cdone[v] = 1'b0;
            n.iok[v] = 1'b0;
         end else if (s.inj_drv[v]) begin
            if (s.tmr[v] != CTRL_LAST)
               n.tmr[v] = TMR_W'(s.tmr[v] + 1'b1);
            if (s.pin[P_ISH + v])
               n.shseen[v] = 1'b1;
            if (s.pin[P_COK + v])
               n.iok[v] = 1'b1;
            if (rise[P_CT + v] && !s.cdone[v]) begin
               n.cdone[v] = 1'b1;
               if (s.tmr[v] >= s.cal.ct_min && s.tmr[v] <= s.cal.ct_max) begin
                  n.adv[v] = s.tmr[v];
                  n.ctf[v] = 1'b0;
               end else
                  n.ctf[v] = 1'b1;
            end
            // drive is left on after a control fault; next cycle retries
            if (s.tmr[v] == CTRL_LAST && !s.iok[v] && !s.pin[P_COK + v])
               n.clf[v] = 1'b1;
            else if (s.iok[v])
               n.clf[v] = 1'b0;
            if (!n.inj_drv[v]) begin
               n.icnt[v] = succ(s.icnt[v], s.shseen[v], s.cal.short_cnt);
               if (!s.cdone[v])
                  n.ctf[v] = 1'b1;
            end
         end
         // a disabled output cannot show its short, so once stored the
         // short is no longer present and a clear may release the valve
         pres[IB + v] = s.icnt[v] >= s.cal.short_cnt && !s.st[IB + v];
         pres[CB + v] = s.ctf[v];
         pres[LB + v] = s.clf[v];
      end

      // proportional valves
      for (int p = 0; p < NP; p++) begin
         n.p_drv[p] = prop_cmd_in[p] && !s.st[PB + p];
         if (n.p_drv[p] && !s.p_drv[p])
            n.p_seen[p] = 1'b0;
         else if (s.p_drv[p] && s.pin[P_PSH + p])
            n.p_seen[p] = 1'b1;
         if (s.p_drv[p] && !n.p_drv[p])
            n.pcnt[p] = succ(s.pcnt[p], s.p_seen[p], s.cal.short_cnt);
         pres[PB + p] = s.pcnt[p] >= s.cal.short_cnt && !s.st[PB + p];
      end

      // starter
      n.str_drv = starter_cmd_in && !s.st[F_STR_SH];
      fin = s.str_drv && !n.str_drv;
      if (n.str_drv && !s.str_drv)
         n.str_seen = 1'b0;
      else if (s.str_drv && s.pin[P_SSH])
         n.str_seen = 1'b1;
      if (fin)
         n.scnt = succ(s.scnt, s.str_seen, STARTER_SHORTS);
      pres[F_STR_SH] = s.scnt >= STARTER_SHORTS && !s.st[F_STR_SH];
      pres[F_STR_OPEN] = !s.str_drv && s.pin[P_SOP];

      // fault memory: a new event wins over a clear in the same cycle
      set = pres;
      n.pres = pres;
      n.st = s.st | set;
      if (clr_req_in && int'(clr_idx_in) < NF && !pres[clr_idx_in]) begin
         n.st[clr_idx_in] = set[clr_idx_in];
         // restart successive counting so a released output starts clean
         if (int'(clr_idx_in) == F_STR_SH)
            n.scnt = '0;
         for (int v = 0; v < NV; v++)
            if (int'(clr_idx_in) == IB + v)
               n.icnt[v] = '0;
         for (int p = 0; p < NP; p++)
            if (int'(clr_idx_in) == PB + p)
               n.pcnt[p] = '0;
      end
      n.rd_code = code_of(int'(rd_idx_in), s.shi);
      n.rd_st = int'(rd_idx_in) < NF && s.st[rd_idx_in];
      n.rd_pr = int'(rd_idx_in) < NF && s.pres[rd_idx_in];
      n.any = |s.st;
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         s <= '0;
         s.cal <= CAL_DEFAULT;
      end else begin
         s <= n;
      end
   end

   assign sens_value_out = s.sout;
   assign pos_src_out = s.pos;
   assign inj_drive_out = s.inj_drv;
   assign inj_adv_out = s.adv;
   assign prop_drive_out = s.p_drv;
   assign starter_drive_out = s.str_drv;
   assign rd_code_out = s.rd_code;
   assign rd_stored_out = s.rd_st;
   assign rd_present_out = s.rd_pr;
   assign fault_any_out = s.any;

   // ==========================================================
   // checks
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);

   a_inj_short_off: assert property (
      (inj_drive_out & $past(s.st[IB +: NV])) == '0)
      else $error("injector driven while short stored");
   a_starter_inhibit: assert property (s.st[F_STR_SH] |=>
      !starter_drive_out) else $error("starter driven while short stored");
   a_clear_keeps: assert property (clr_req_in && int'(clr_idx_in) < NF &&
      s.st[clr_idx_in] && n.pres[clr_idx_in] |=> s.st[$past(clr_idx_in)])
      else $error("present fault removed by clear");
   a_crank_backup: assert property (s.pres[F_CRK_TMO] |->
      pos_src_out == POS_CAM) else $error("no cam backup");
   a_cam_backup: assert property ((s.pres[F_CAM_TMO] ||
      s.pres[F_CAM_GO]) && !s.pres[F_CRK_TMO] && !s.pres[F_CRK_GO] |->
      pos_src_out == POS_CRANK) else $error("no crank backup");
   a_pol_diag_only: assert property ($rose(s.st[F_CRK_POL]) |->
      $past(s.pin[P_DIAG])) else $error("polarity stored outside routine");
   a_sens_hold: assert property (sens_valid_in && sens_idx_in == '0 &&
      sens_val_in > s.cal.sens_max && !s.st[SLOT_SENS] && !n.st[SLOT_SENS]
      |=> $stable(sens_value_out[0]))
      else $error("sensor value changed on out of range sample");
   a_ctrl_timeout: assert property (s.inj_drv[0] && n.inj_drv[0] &&
      s.tmr[0] == CTRL_LAST && !s.iok[0] && !s.pin[P_COK] |=>
      s.clf[0] && inj_drive_out[0]) else $error("control fault missed");
   a_starter_count: assert property ($rose(s.pres[F_STR_SH]) |->
      $past(s.scnt, 2) == 3'(STARTER_SHORTS - 3'h1) &&
      s.scnt == STARTER_SHORTS)
      else $error("starter short stored on wrong count");
endmodule // efm_fault_monitor
`default_nettype wire

// file: hw/efm_pkg.sv
// constants, calibration layout and fault code format for the fault monitor
// Summary of operation
// - out-of-range sensor sample is sporadic; last valid value kept.
// - range fault stored after a debounce period; replacement value used.
// - below minimum is short to ground, above maximum is over voltage.
// - crank mark expected every 10 degrees; missing marks store time-out.
// - crank time-out, short or open switches position to cam backup.
// - crank polarity checked only during external service routine; no reaction.
// - cam marks every 60 degrees plus one at 55; missing marks store time-out.
// - cam time-out, short or open with no crank fault switches position to crank backup.
// - reversed cam sensor lines store a cam polarity fault.
// - injector short stored after several successive shorted activations.
// - stored injector short keeps valve off until restart or clear.
// - contact delay measured from switch-on; valve start advanced by it.
// - contact outside window flags fault; last valid delay kept.
// - valve current not above threshold by 1 ms flags control fault.
// - after control fault valve stays driven; retried next working cycle.
// - successive proportional valve lead shorts stored; valve closed until release.
// - three successive starter ground shorts store a starter fault.
// - stored starter short inhibits starter drive until restart or clear.
// - undriven starter output level reveals open circuit; no reaction.
// - each fault marked present or not; clear never removes present faults.
// - fault code is priority digit, two path digits, two type digits.
`default_nettype none
package efm_pkg;
   // ==========================================================
   // timing, widths, starter short count and sensor replacement value
   localparam int CLK_MHZ = 100;
   localparam int CTRL_TMO_MS = 1;
   localparam int CTRL_TMO_CYC = CTRL_TMO_MS * 1000 * CLK_MHZ;
   localparam int TMR_W = 17;
   localparam int SENS_W = 10;
   localparam logic [2:0] STARTER_SHORTS = 3'h3;
   localparam logic [SENS_W-1:0] SENS_REPL = 10'h200;
   // ==========================================================
   // synchronised pin bit positions
   localparam int P_CRK = 0;
   localparam int P_CAM = 1;
   localparam int P_CRKGO = 2;
   localparam int P_CAMGO = 3;
   localparam int P_CRKPOL = 4;
   localparam int P_CAMPOL = 5;
   localparam int P_DIAG = 6;
   localparam int P_ISH = 7;
   // ==========================================================
   // fixed fault slots, sensors and valves follow from SLOT_SENS
   localparam int F_CRK_TMO = 0;
   localparam int F_CRK_POL = 1;
   localparam int F_CRK_GO = 2;
   localparam int F_CAM_TMO = 3;
   localparam int F_CAM_POL = 4;
   localparam int F_CAM_GO = 5;
   localparam int F_STR_SH = 6;
   localparam int F_STR_OPEN = 7;
   localparam int SLOT_SENS = 8;
   // ==========================================================
   // code digits (binary, converted to bcd when read out)
   localparam logic [6:0] PATH_CRANK = 7'h02;
   localparam logic [6:0] PATH_CAM = 7'h03;
   localparam logic [6:0] PATH_SENS0 = 7'h0A;
   localparam logic [6:0] PATH_INJ0 = 7'h32;
   localparam logic [6:0] PATH_PROP0 = 7'h46;
   localparam logic [6:0] PATH_STARTER = 7'h50;
   localparam logic [6:0] TYP_TMO = 7'h01;
   localparam logic [6:0] TYP_POL = 7'h02;
   localparam logic [6:0] TYP_GND = 7'h03;
   localparam logic [6:0] TYP_OPEN = 7'h04;
   localparam logic [6:0] TYP_OVER = 7'h05;
   localparam logic [6:0] TYP_CONTACT = 7'h06;
   localparam logic [6:0] TYP_CTRL = 7'h07;
   localparam logic [3:0] PRIO_LOW = 4'h0;
   localparam logic [3:0] PRIO_MID = 4'h1;
   localparam logic [3:0] PRIO_HIGH = 4'h2;
   // ==========================================================
   // types
   typedef struct packed {
      logic [3:0] prio;
      logic [7:0] path;
      logic [7:0] ftype;
   } efm_code_type;
   typedef struct packed {
      logic [15:0] crank_tmo;
      logic [15:0] cam_tmo;
      logic [15:0] sens_deb;
      logic [SENS_W-1:0] sens_min;
      logic [SENS_W-1:0] sens_max;
      logic [2:0] short_cnt;
      logic [TMR_W-1:0] ct_min;
      logic [TMR_W-1:0] ct_max;
   } efm_cal_type;
   typedef enum logic [1:0] {POS_NORMAL, POS_CAM, POS_CRANK} efm_pos_type;
   localparam efm_cal_type CAL_DEFAULT = '{crank_tmo: 16'h2000,
      cam_tmo: 16'hC000, sens_deb: 16'h1000, sens_min: 10'h020,
      sens_max: 10'h3E0, short_cnt: 3'h3, ct_min: 17'h00064,
      ct_max: 17'h0C350};
   function automatic logic [7:0] to_bcd(input logic [6:0] v);
      logic [6:0] tens;
      tens = v / 7'h0A;
      return {tens[3:0], 4'(v - tens * 7'h0A)};
   endfunction
endpackage
`default_nettype wire

// file: verif/efm_drv_model.sv
// valve driver stand-in: armature contact, current and short replies
`default_nettype none
module efm_drv_model #(
   parameter int NV = 6
) (
   // clock
   input wire logic clk_in,
   // drive seen at the valves and behaviour knobs
   input wire logic [NV-1:0] drive_in,
   input wire logic [7:0] contact_dly_in,
   input wire logic [7:0] cur_dly_in,
   input wire logic short_en_in,
   // replies to the monitor
   output logic [NV-1:0] contact_out,
   output logic [NV-1:0] cur_ok_out,
   output logic [NV-1:0] short_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [NV-1:0][7:0] age = '0;
   // age saturates so a slow valve never wraps into a fast one
   always @(posedge clk_in) begin
      for (int v = 0; v < NV; v++) begin
         if (!drive_in[v])
            age[v] <= 8'h00;
         else if (age[v] != 8'hFF)
            age[v] <= age[v] + 8'h01;
      end
   end
   // an undriven valve shows no contact, no current and no short
   always_comb begin
      for (int v = 0; v < NV; v++) begin
         contact_out[v] = drive_in[v] && (age[v] >= contact_dly_in);
         cur_ok_out[v] = drive_in[v] && (age[v] >= cur_dly_in);
         short_out[v] = drive_in[v] && short_en_in;
      end
   end
endmodule // efm_drv_model
`default_nettype wire

// file: verif/efm_fault_monitor_tb.sv
// self-checking bench for the fault monitor
`default_nettype none
module efm_fault_monitor_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import efm_pkg::*;
   logic clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   efm_cal_type cal = CAL_DEFAULT;
   logic cal_ld = 1'b0;
   logic s_vld = 1'b0;
   logic crk = 1'b0;
   logic crk_go = 1'b0;
   logic cam = 1'b0;
   logic cam_go = 1'b0;
   logic crk_pol = 1'b0;
   logic cam_pol = 1'b0;
   logic diag = 1'b0;
   logic [1:0] s_idx = '0;
   logic [SENS_W-1:0] s_val = '0;
   logic [SENS_W-1:0] lastv [4];
   logic [5:0] inj_cmd = '0;
   logic [5:0] inj_drv, contact, cur_ok, ishort;
   logic [1:0] p_cmd = '0;
   logic [1:0] p_drv;
   logic st_cmd = 1'b0;
   logic st_sh = 1'b0;
   logic st_open = 1'b0;
   logic st_drv, clr, stored, present, any;
   logic [4:0] rd_idx = '0;
   logic [4:0] clr_idx = '0;
   logic [7:0] c_dly = 8'h14;
   logic [7:0] i_dly = 8'h08;
   logic sh_en = 1'b0;
   logic [3:0][SENS_W-1:0] sval;
   logic [5:0][TMR_W-1:0] adv;
   logic [TMR_W-1:0] adv0;
   efm_pos_type pos;
   efm_code_type code;
   int n_fail = 0;
   int samples_checked = 0;
   int seed = 54;
   int cycles = 0;
   initial clr = 1'b0;
   always #5 clk_in = ~clk_in;
   efm_fault_monitor #(.NS(4), .NV(6), .NP(2), .CTRL_TMO_CYC(200))
   i_efm_fault_monitor (.clk_in(clk_in), .rst_n_in(rst_n_in),
      .cal_in(cal), .cal_load_in(cal_ld), .sens_valid_in(s_vld),
      .sens_idx_in(s_idx), .sens_val_in(s_val), .crank_mark_in(crk),
      .cam_mark_in(cam), .crank_gnd_open_in(crk_go),
      .cam_gnd_open_in(cam_go), .crank_pol_in(crk_pol),
      .cam_pol_in(cam_pol), .diag_routine_in(diag), .inj_cmd_in(inj_cmd),
      .inj_short_in(ishort), .inj_contact_in(contact),
      .inj_cur_ok_in(cur_ok), .prop_cmd_in(p_cmd),
      .prop_short_in(p_drv & {2{st_sh}}), .starter_cmd_in(st_cmd),
      .starter_short_in(st_drv & st_sh), .starter_open_in(st_open),
      .rd_idx_in(rd_idx), .clr_req_in(clr), .clr_idx_in(clr_idx),
      .sens_value_out(sval), .pos_src_out(pos), .inj_drive_out(inj_drv),
      .inj_adv_out(adv), .prop_drive_out(p_drv),
      .starter_drive_out(st_drv), .rd_code_out(code),
      .rd_stored_out(stored), .rd_present_out(present),
      .fault_any_out(any));
   efm_drv_model #(.NV(6)) i_efm_drv_model (.clk_in(clk_in),
      .drive_in(inj_drv), .contact_dly_in(c_dly), .cur_dly_in(i_dly),
      .short_en_in(sh_en), .contact_out(contact), .cur_ok_out(cur_ok),
      .short_out(ishort));
   // ==========================================================
   // helpers
   task automatic cyc(input int n);
      repeat (n) @(negedge clk_in);
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_rng(input logic [31:0] got, input int lo, hi);
      samples_checked++;
      if (got < lo || got > hi || $isunknown(got)) begin
         n_fail++;
         $display("[FAIL] %0t got %h out of %0d..%0d", $time, got, lo, hi);
      end
   endtask
   function automatic logic [7:0] bcd(input int v);
      return 8'((v / 10) * 16 + v % 10);
   endfunction
   task automatic rd(input logic [4:0] i);
      rd_idx = i;
      cyc(2);
   endtask
   task automatic clear(input logic [4:0] i);
      clr_idx = i;
      clr = 1'b1;
      cyc(1);
      clr = 1'b0;
      cyc(2);
   endtask
   task automatic samp(input logic [1:0] i, input logic [SENS_W-1:0] v,
         input int n);
      s_idx = i;
      s_val = v;
      s_vld = 1'b1;
      cyc(n);
      s_vld = 1'b0;
      cyc(2);
   endtask
   task automatic tally_and_finish;
      if (n_fail == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // hang guard, well above the roughly 1300 cycles the run needs
   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 10000) begin
         n_fail++;
         tally_and_finish();
      end
   end
   // ==========================================================
   // scenarios
   initial begin
      cal.crank_tmo = 16'h0040;
      cal.cam_tmo = 16'h0080;
      cal.sens_deb = 16'h0010;
      cal.ct_min = 17'h00005;
      cal.ct_max = 17'h00060;
      cyc(4);
      rst_n_in = 1'b1;
      cal_ld = 1'b1;
      cyc(1);
      cal_ld = 1'b0;
      cyc(4);
      chk(any, 1'b0);
      for (int k = 0; k < 8; k++) begin
         lastv[k%4] = 10'h020 + 10'($unsigned($random(seed)) % 960);
         samp(2'(k), lastv[k%4], 1);
         chk(sval[k%4], lastv[k%4]);
      end
      samp(2'h1, 10'h005, 1);
      chk(sval[1], lastv[1]);
      samp(2'h0, 10'h3FF, 1);
      chk(sval[0], lastv[0]);
      samp(2'h1, 10'h005, 28);
      chk(sval[1], SENS_REPL);
      rd(5'd9);
      chk({code.path, code.ftype}, {bcd(11), 8'h03});
      chk(code.prio < 4'h3, 1'b1);
      clear(5'd9);
      rd(5'd9);
      chk(stored, 1'b1);
      samp(2'h1, 10'h100, 1);
      clear(5'd9);
      rd(5'd9);
      chk(stored, 1'b0);
      samp(2'h1, 10'h101, 1);
      chk(sval[1], 10'h101);
      samp(2'h2, 10'h3FF, 28);
      rd(5'd10);
      chk({stored, code.path, code.ftype}, {1'b1, bcd(12), 8'h05});
      inj_cmd = 6'h01;
      cyc(3);
      chk(inj_drv[0], 1'b1);
      cyc(40);
      inj_cmd = 6'h00;
      cyc(3);
      chk_rng(adv[0], 20, 26);
      adv0 = adv[0];
      c_dly = 8'd150;
      inj_cmd = 6'h01;
      cyc(180);
      inj_cmd = 6'h00;
      cyc(3);
      chk(adv[0], adv0);
      rd(5'd18);
      chk(stored, 1'b1);
      c_dly = 8'h14;
      i_dly = 8'hFF;
      inj_cmd = 6'h01;
      cyc(150);
      rd(5'd24);
      chk(present, 1'b0);
      cyc(65);
      rd(5'd24);
      chk({present, inj_drv[0]}, 2'b11);
      inj_cmd = 6'h00;
      i_dly = 8'h08;
      cyc(3);
      inj_cmd = 6'h01;
      cyc(30);
      inj_cmd = 6'h00;
      rd(5'd24);
      chk(present, 1'b0);
      sh_en = 1'b1;
      for (int k = 0; k < 3; k++) begin
         inj_cmd = 6'h04;
         cyc(30);
         inj_cmd = 6'h00;
         cyc(5);
         rd(5'd14);
         chk(stored, 1'(k == 2));
      end
      inj_cmd = 6'h04;
      sh_en = 1'b0;
      cyc(20);
      chk(inj_drv[2], 1'b0);
      inj_cmd = 6'h00;
      clear(5'd14);
      inj_cmd = 6'h04;
      cyc(3);
      chk(inj_drv[2], 1'b1);
      inj_cmd = 6'h00;
      st_open = 1'b1;
      rd(5'd7);
      cyc(8);
      chk(stored, 1'b1);
      st_open = 1'b0;
      st_sh = 1'b1;
      for (int k = 0; k < 4; k++) begin
         st_cmd = 1'b1;
         p_cmd = 2'h1;
         cyc(3);
         chk({st_drv, p_drv[0]}, {2{1'(k < 3)}});
         cyc(10);
         st_cmd = 1'b0;
         p_cmd = 2'h0;
         cyc(5);
      end
      st_sh = 1'b0;
      clear(5'd6);
      clear(5'd30);
      st_cmd = 1'b1;
      p_cmd = 2'h1;
      cyc(3);
      chk({st_drv, p_drv[0]}, 2'b11);
      st_cmd = 1'b0;
      p_cmd = 2'h0;
      crk_go = 1'b1;
      cyc(6);
      chk(pos, POS_CAM);
      crk_go = 1'b0;
      repeat (10) begin
         crk = 1'b1;
         cyc(4);
         crk = 1'b0;
         cyc(4);
      end
      chk(pos, POS_NORMAL);
      cyc(100);
      chk(pos, POS_CAM);
      rd(5'd0);
      chk({stored, any}, 2'b11);
      crk_pol = 1'b1;
      rd(5'd1);
      cyc(6);
      chk(stored, 1'b0);
      diag = 1'b1;
      cyc(8);
      chk(stored, 1'b1);
      crk_pol = 1'b0;
      diag = 1'b0;
      cam_pol = 1'b1;
      rd(5'd4);
      cyc(6);
      chk(stored, 1'b1);
      cam_pol = 1'b0;
      // cam marks stop after six crank marks while the crank keeps going
      for (int k = 0; k < 30; k++) begin
         crk = 1'b1;
         cam = 1'(k < 6);
         cam_go = 1'(k == 1 || k == 2);
         cyc(4);
         if (k == 2)
            chk(pos, POS_CRANK);
         if (k == 5)
            chk(pos, POS_NORMAL);
         crk = 1'b0;
         cam = 1'b0;
         cyc(4);
      end
      chk(pos, POS_CRANK);
      rd(5'd3);
      chk(stored, 1'b1);
      tally_and_finish();
   end
endmodule // efm_fault_monitor_tb
`default_nettype wire
